// ===== rtl/ssl_strap_latch.sv
// soft strap latch with loader override, revert and register defaults
// Function
// - capture pinned strap levels only when power-on or external reset releases.
// - loader writes replace captured strap values; every strap can be overridden.
// - each strap is a direct configuration value or a register default.
// - straps without a pin take a fixed built-in value.
// - digital reset or reload reverts straps to the captured values.
// - digital reset and reload never re-sample the strap pins.
// - led select bit high makes pin an LED, low a general I/O.
// - one pin defaults all eight led select bits; loader sets each.
// - the two led function straps default the function field bit by bit.
// - crossover strap high enables auto crossover, only while override is clear.
// - with the override bit set, the crossover strap has no effect.
// - manual crossover strap picks straight or crossed; tie-off is zero.
// - negotiation strap defaults the negotiation enable bit.
// - negotiation strap also shapes speed, duplex, advert and mode defaults.
// - speed strap defaults 10 or 100 Mbps, shapes advert and mode.
// - digital reset starts the eeprom loader again.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ssl_map.svh"

module ssl_strap_latch
#(
	parameter int ADDR_W = 8
)
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic external_reset_pin_n_in,
	input wire logic led_select_strap_in,
	input wire logic [1:0] led_function_strap_in,
	input wire logic auto_crossover_strap_in,
	input wire logic negotiation_strap_in,
	input wire logic speed_strap_in,
	input wire logic eeprom_present_in,
	input wire logic loader_wr_in,
	input wire ssl_pkg::ssl_strap_t loader_data_in,
	input wire logic loader_done_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic loader_start_out,
	output logic straps_valid_out,
	output logic [7:0] led_select_bits_out,
	output logic [1:0] led_function_bits_out,
	output logic crossover_auto_out,
	output logic crossover_cross_out,
	output logic negotiation_enable_bit_out,
	output logic speed_select_low_bit_out,
	output logic duplex_select_bit_out,
	output logic advert_10fd_out,
	output logic advert_10hd_out,
	output logic [2:0] special_mode_out
);

	// pin synchronisers
	logic [6:0] pin_meta_q;
	logic [6:0] pin_sync_q;
	logic ext_rst_ok;

	// capture sequencing
	logic capture_pending_q;
	logic [1:0] capture_wait_q;
	logic capture_fire;

	// strap values
	ssl_pkg::ssl_strap_t pin_now;
	ssl_pkg::ssl_strap_t captured;
	ssl_pkg::ssl_strap_t eff_q;
	ssl_pkg::ssl_strap_t eff_d;
	ssl_pkg::ssl_phy_t phy_d;
	logic load_now;

	// soft resets
	logic wr_dig_rst;
	logic wr_reload;
	logic revert;
	logic loader_take;
	logic load_busy_q;

	// software visible registers
	logic [7:0] led_sel_q;
	logic [1:0] led_function_bits_q;
	logic neg_en_q;
	logic speed_q;
	logic duplex_q;
	logic adv_10fd_q;
	logic adv_10hd_q;
	logic [2:0] mode_q;
	logic xo_ovr_q;
	logic xo_auto_q;
	logic xo_cross_q;
	logic xo_auto_out_q;
	logic xo_cross_out_q;
	logic loader_start_q;
	logic straps_valid_q;
	logic [31:0] rdata_q;

	// register defaults shaped by negotiation and speed straps
	function automatic ssl_pkg::ssl_phy_t derive_phy
	(
		input ssl_pkg::ssl_strap_t s
	);
		ssl_pkg::ssl_phy_t d;
		d.neg_en = s.neg_en;
		d.speed = s.neg_en | s.speed;
		d.duplex = s.neg_en | s.duplex;
		d.adv_10fd = s.neg_en | (~s.speed & s.duplex);
		d.adv_10hd = s.neg_en | ~s.speed;
		if (s.neg_en)
			d.mode = `SSL_MODE_ALL_CAP;
		else
			d.mode = {1'h0, s.speed, s.duplex};
		return d;
	endfunction

	// two-stage synchroniser for the reset pin and strap pins
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pin_meta_q <= 7'h00;
			pin_sync_q <= 7'h00;
		end
		else
		begin
			pin_meta_q <= {external_reset_pin_n_in, led_select_strap_in,
				led_function_strap_in, auto_crossover_strap_in,
				negotiation_strap_in, speed_strap_in};
			pin_sync_q <= pin_meta_q;
		end
	end

	assign ext_rst_ok = pin_sync_q[6];

	// strap set as seen on the pins now, tie-offs for unpinned ones
	always_comb
	begin
		pin_now.led_sel = {8{pin_sync_q[5]}};
		pin_now.led_function_bits = pin_sync_q[4:3];
		pin_now.auto_xo = pin_sync_q[2];
		pin_now.manual_xo = `SSL_TIE_MANUAL_XO;
		pin_now.neg_en = pin_sync_q[1];
		pin_now.speed = pin_sync_q[0];
		pin_now.duplex = `SSL_TIE_DUPLEX;
	end

	// capture waits for the pins to pass both sync stages
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			capture_pending_q <= 1'h1;
			capture_wait_q <= 2'h0;
		end
		else if (!ext_rst_ok)
		begin
			capture_pending_q <= 1'h1;
			capture_wait_q <= 2'h0;
		end
		else if (capture_pending_q)
		begin
			if (capture_wait_q == `SSL_CAPTURE_WAIT)
				capture_pending_q <= 1'h0;
			else
				capture_wait_q <= capture_wait_q + 2'h1;
		end
	end

	// single capture on hard reset release
	assign capture_fire = capture_pending_q & ext_rst_ok &
		(capture_wait_q == `SSL_CAPTURE_WAIT);

	// held copy of the captured levels
	ssl_capture_store u_store
	(
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.capture_in(capture_fire),
		.data_in(pin_now),
		.data_out(captured)
	);

	// soft reset strobes from the register port
	assign wr_dig_rst = reg_wr_in & ext_rst_ok &
		(reg_addr_in == ADDR_W'(`SSL_OFF_RST_CONTROL)) &
		reg_wdata_in[`SSL_BIT_DIG_RST];
	assign wr_reload = reg_wr_in & ext_rst_ok &
		(reg_addr_in == ADDR_W'(`SSL_OFF_EEP_COMMAND)) &
		reg_wdata_in[`SSL_BIT_RELOAD];
	assign revert = ~capture_pending_q & (wr_dig_rst | wr_reload);
	assign loader_take = ~capture_pending_q & ~revert &
		loader_wr_in & eeprom_present_in;

	// next effective straps: capture, then revert, then loader
	always_comb
	begin
		eff_d = eff_q;
		load_now = 1'h0;
		if (capture_fire)
		begin
			eff_d = pin_now;
			load_now = 1'h1;
		end
		else if (revert)
		begin
			eff_d = captured;
			load_now = 1'h1;
		end
		else if (loader_take)
		begin
			eff_d = loader_data_in;
			load_now = 1'h1;
		end
	end

	assign phy_d = derive_phy(eff_d);

	// effective strap values
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			eff_q <= '0;
		else
			eff_q <= eff_d;
	end

	// loader busy flag, start set wins over done
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			load_busy_q <= 1'h0;
		else if (revert || capture_fire)
			load_busy_q <= 1'h1;
		else if (loader_done_in || !eeprom_present_in)
			load_busy_q <= 1'h0;
	end

	// loader start pulse after any reset that reloads
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			loader_start_q <= 1'h0;
		else
			loader_start_q <= revert | capture_fire;
	end

	// straps valid once captured, dropped by external reset
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			straps_valid_q <= 1'h0;
		else if (!ext_rst_ok)
			straps_valid_q <= 1'h0;
		else if (capture_fire)
			straps_valid_q <= 1'h1;
	end

	// led configuration register, defaults from the straps
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			led_sel_q <= 8'h00;
			led_function_bits_q <= 2'h0;
		end
		else if (load_now)
		begin
			led_sel_q <= eff_d.led_sel;
			led_function_bits_q <= eff_d.led_function_bits;
		end
		else if (reg_wr_in && reg_addr_in == ADDR_W'(`SSL_OFF_LED_CONFIG))
		begin
			led_sel_q <= reg_wdata_in[`SSL_MSB_LED_SEL:`SSL_LSB_LED_SEL];
			led_function_bits_q <= reg_wdata_in[`SSL_MSB_LED_FUNCTION_BITS:`SSL_LSB_LED_FUNCTION_BITS];
		end
	end

	// port 1 basic control bits
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			neg_en_q <= 1'h0;
			speed_q <= 1'h0;
			duplex_q <= 1'h0;
		end
		else if (load_now)
		begin
			neg_en_q <= phy_d.neg_en;
			speed_q <= phy_d.speed;
			duplex_q <= phy_d.duplex;
		end
		else if (reg_wr_in && reg_addr_in == ADDR_W'(`SSL_OFF_BASIC_CTRL))
		begin
			neg_en_q <= reg_wdata_in[`SSL_BIT_NEG_EN];
			speed_q <= reg_wdata_in[`SSL_BIT_SPEED];
			duplex_q <= reg_wdata_in[`SSL_BIT_DUPLEX];
		end
	end

	// negotiation advertisement bits
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			adv_10fd_q <= 1'h0;
			adv_10hd_q <= 1'h0;
		end
		else if (load_now)
		begin
			adv_10fd_q <= phy_d.adv_10fd;
			adv_10hd_q <= phy_d.adv_10hd;
		end
		else if (reg_wr_in && reg_addr_in == ADDR_W'(`SSL_OFF_NEG_ADVERT))
		begin
			adv_10fd_q <= reg_wdata_in[`SSL_BIT_ADV_10FD];
			adv_10hd_q <= reg_wdata_in[`SSL_BIT_ADV_10HD];
		end
	end

	// special mode field
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			mode_q <= 3'h0;
		else if (load_now)
			mode_q <= phy_d.mode;
		else if (reg_wr_in && reg_addr_in == ADDR_W'(`SSL_OFF_SPEC_MODES))
			mode_q <= reg_wdata_in[`SSL_MSB_MODE:`SSL_LSB_MODE];
	end

	// crossover override bits, untouched by soft resets
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			xo_ovr_q <= 1'h0;
			xo_auto_q <= 1'h0;
			xo_cross_q <= 1'h0;
		end
		else if (!ext_rst_ok)
		begin
			xo_ovr_q <= 1'h0;
			xo_auto_q <= 1'h0;
			xo_cross_q <= 1'h0;
		end
		else if (reg_wr_in && reg_addr_in == ADDR_W'(`SSL_OFF_SPEC_CTRL))
		begin
			xo_ovr_q <= reg_wdata_in[`SSL_BIT_XO_OVR];
			xo_auto_q <= reg_wdata_in[`SSL_BIT_XO_AUTO];
			xo_cross_q <= reg_wdata_in[`SSL_BIT_XO_CROSS];
		end
	end

	// crossover as direct configuration from straps or override
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			xo_auto_out_q <= 1'h0;
			xo_cross_out_q <= 1'h0;
		end
		else if (xo_ovr_q)
		begin
			xo_auto_out_q <= xo_auto_q;
			xo_cross_out_q <= xo_cross_q;
		end
		else
		begin
			xo_auto_out_q <= eff_q.auto_xo;
			xo_cross_out_q <= ~eff_q.auto_xo & eff_q.manual_xo;
		end
	end

	// read data one cycle after the strobe, zero when unmapped
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rdata_q <= 32'h0000_0000;
		else if (reg_rd_in)
		begin
			rdata_q <= 32'h0000_0000;
			case (reg_addr_in)
				ADDR_W'(`SSL_OFF_RST_CONTROL):
					rdata_q[`SSL_BIT_DIG_RST] <= load_busy_q;
				ADDR_W'(`SSL_OFF_EEP_COMMAND):
				begin
					rdata_q[`SSL_BIT_LOAD_BUSY] <= load_busy_q;
					rdata_q[`SSL_BIT_EEP_PRESENT] <= eeprom_present_in;
				end
				ADDR_W'(`SSL_OFF_LED_CONFIG):
				begin
					rdata_q[`SSL_MSB_LED_SEL:`SSL_LSB_LED_SEL] <= led_sel_q;
					rdata_q[`SSL_MSB_LED_FUNCTION_BITS:`SSL_LSB_LED_FUNCTION_BITS] <= led_function_bits_q;
				end
				ADDR_W'(`SSL_OFF_BASIC_CTRL):
				begin
					rdata_q[`SSL_BIT_NEG_EN] <= neg_en_q;
					rdata_q[`SSL_BIT_SPEED] <= speed_q;
					rdata_q[`SSL_BIT_DUPLEX] <= duplex_q;
				end
				ADDR_W'(`SSL_OFF_NEG_ADVERT):
				begin
					rdata_q[`SSL_BIT_ADV_10FD] <= adv_10fd_q;
					rdata_q[`SSL_BIT_ADV_10HD] <= adv_10hd_q;
				end
				ADDR_W'(`SSL_OFF_SPEC_MODES):
					rdata_q[`SSL_MSB_MODE:`SSL_LSB_MODE] <= mode_q;
				ADDR_W'(`SSL_OFF_SPEC_CTRL):
				begin
					rdata_q[`SSL_BIT_XO_OVR] <= xo_ovr_q;
					rdata_q[`SSL_BIT_XO_AUTO] <= xo_auto_q;
					rdata_q[`SSL_BIT_XO_CROSS] <= xo_cross_q;
				end
				ADDR_W'(`SSL_OFF_CAPTURED):
					rdata_q[`SSL_MSB_CAPTURED:`SSL_LSB_CAPTURED] <= captured;
				default:
					rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata_out = rdata_q;
	assign loader_start_out = loader_start_q;
	assign straps_valid_out = straps_valid_q;
	assign led_select_bits_out = led_sel_q;
	assign led_function_bits_out = led_function_bits_q;
	assign crossover_auto_out = xo_auto_out_q;
	assign crossover_cross_out = xo_cross_out_q;
	assign negotiation_enable_bit_out = neg_en_q;
	assign speed_select_low_bit_out = speed_q;
	assign duplex_select_bit_out = duplex_q;
	assign advert_10fd_out = adv_10fd_q;
	assign advert_10hd_out = adv_10hd_q;
	assign special_mode_out = mode_q;

endmodule

`default_nettype wire

// ===== shared/ssl_map.svh
// register offsets, bit positions, tie-offs and timing counts of the strap latch
`ifndef SSL_MAP_SVH
`define SSL_MAP_SVH

// register offsets, one aligned word each
`define SSL_OFF_RST_CONTROL 8'h00
`define SSL_OFF_EEP_COMMAND 8'h04
`define SSL_OFF_LED_CONFIG 8'h08
`define SSL_OFF_BASIC_CTRL 8'h0C
`define SSL_OFF_NEG_ADVERT 8'h10
`define SSL_OFF_SPEC_MODES 8'h14
`define SSL_OFF_SPEC_CTRL 8'h18
`define SSL_OFF_CAPTURED 8'h1C

// bit positions inside the registers
`define SSL_BIT_DIG_RST 0
`define SSL_BIT_RELOAD 0
`define SSL_BIT_LOAD_BUSY 1
`define SSL_BIT_EEP_PRESENT 2
`define SSL_LSB_LED_SEL 0
`define SSL_MSB_LED_SEL 7
`define SSL_LSB_LED_FUNCTION_BITS 8
`define SSL_MSB_LED_FUNCTION_BITS 9
`define SSL_BIT_SPEED 13
`define SSL_BIT_NEG_EN 12
`define SSL_BIT_DUPLEX 8
`define SSL_BIT_ADV_10FD 6
`define SSL_BIT_ADV_10HD 5
`define SSL_LSB_MODE 5
`define SSL_MSB_MODE 7
`define SSL_BIT_XO_OVR 15
`define SSL_BIT_XO_AUTO 14
`define SSL_BIT_XO_CROSS 13
`define SSL_LSB_CAPTURED 0
`define SSL_MSB_CAPTURED 14

// built-in values of straps without a pin, and the mode default used when negotiation is enabled
`define SSL_TIE_MANUAL_XO 1'h0
`define SSL_TIE_DUPLEX 1'h1
`define SSL_MODE_ALL_CAP 3'h7

// cycles after reset release until the synchronised pins are valid
`define SSL_CAPTURE_WAIT 2'h2

`endif

// ===== shared/ssl_pkg.sv
// types shared by the strap latch design files
package ssl_pkg;

	// one full set of soft strap values
	typedef struct packed {
		logic [7:0] led_sel;
		logic [1:0] led_function_bits;
		logic auto_xo;
		logic manual_xo;
		logic neg_en;
		logic speed;
		logic duplex;
	} ssl_strap_t;

	// register defaults derived from the straps
	typedef struct packed {
		logic neg_en;
		logic speed;
		logic duplex;
		logic adv_10fd;
		logic adv_10hd;
		logic [2:0] mode;
	} ssl_phy_t;

endpackage

// ===== rtl/ssl_capture_store.sv
// held copy of the strap levels caught at the last hard reset
`timescale 1ns/10ps
`default_nettype none

module ssl_capture_store
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic capture_in,
	input wire ssl_pkg::ssl_strap_t data_in,
	output var ssl_pkg::ssl_strap_t data_out
);

	ssl_pkg::ssl_strap_t store_q;

	// written only by a hard-reset capture, never by soft resets
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			store_q <= '0;
		else if (capture_in)
			store_q <= data_in;
	end

	assign data_out = store_q;

endmodule

`default_nettype wire

// ===== tb/ssl_latch_props.sv
// port assertions for the soft strap latch
`timescale 1ns/10ps
`default_nettype none
`include "ssl_map.svh"

module ssl_latch_props
#(
	parameter int ADDR_W = 8
)
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic eeprom_present_in,
	input wire logic loader_wr_in,
	input wire ssl_pkg::ssl_strap_t loader_data_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic loader_start_out,
	input wire logic straps_valid_out,
	input wire logic [7:0] led_select_bits_out,
	input wire logic [1:0] led_function_bits_out,
	input wire logic crossover_auto_out,
	input wire logic crossover_cross_out,
	input wire logic negotiation_enable_bit_out,
	input wire logic speed_select_low_bit_out,
	input wire logic duplex_select_bit_out,
	input wire logic advert_10fd_out,
	input wire logic advert_10hd_out,
	input wire logic [2:0] special_mode_out
);
	// one clock domain, checks off in reset
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// loader word taken by the latch
	sequence load_s;
		loader_wr_in && eeprom_present_in && straps_valid_out && !reg_wr_in;
	endsequence

	// override write, then a quiet cycle
	sequence ovr_s;
		reg_wr_in && reg_wdata_in[15] && straps_valid_out
			&& reg_addr_in == `SSL_OFF_SPEC_CTRL ##1 !reg_wr_in;
	endsequence

	start_pulse_a:
		assert property (loader_start_out |=> !loader_start_out)
		else $error("start pulse too long");
	valid_start_a:
		assert property ($rose(straps_valid_out) |-> loader_start_out)
		else $error("capture without loader start");
	duplex_tie_a:
		assert property (loader_start_out |-> duplex_select_bit_out)
		else $error("duplex default not set");
	neg_shape_a:
		assert property (loader_start_out && negotiation_enable_bit_out |->
			speed_select_low_bit_out && advert_10fd_out && advert_10hd_out
			&& special_mode_out == `SSL_MODE_ALL_CAP)
		else $error("negotiation defaults wrong");
	speed_shape_a:
		assert property (loader_start_out && !negotiation_enable_bit_out |->
			advert_10hd_out == !speed_select_low_bit_out
			&& advert_10fd_out == !speed_select_low_bit_out
			&& special_mode_out == {1'h0, speed_select_low_bit_out, 1'h1})
		else $error("speed defaults wrong");
	cross_tie_a:
		assert property ($rose(straps_valid_out) |-> ##2 !crossover_cross_out)
		else $error("manual crossover not straight");
	load_apply_a:
		assert property (load_s |=>
			led_select_bits_out == $past(loader_data_in.led_sel)
			&& led_function_bits_out == $past(loader_data_in.led_function_bits)
			&& negotiation_enable_bit_out == $past(loader_data_in.neg_en))
		else $error("loader word not applied");
	ovr_follow_a:
		assert property (ovr_s |-> ##1
			crossover_auto_out == $past(reg_wdata_in[14], 2)
			&& crossover_cross_out == $past(reg_wdata_in[13], 2))
		else $error("override not followed");
endmodule

bind ssl_strap_latch ssl_latch_props #(.ADDR_W(ADDR_W)) props_i (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
	.eeprom_present_in(eeprom_present_in), .loader_wr_in(loader_wr_in),
	.loader_data_in(loader_data_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.loader_start_out(loader_start_out), .straps_valid_out(straps_valid_out),
	.led_select_bits_out(led_select_bits_out),
	.led_function_bits_out(led_function_bits_out),
	.crossover_auto_out(crossover_auto_out),
	.crossover_cross_out(crossover_cross_out),
	.negotiation_enable_bit_out(negotiation_enable_bit_out),
	.speed_select_low_bit_out(speed_select_low_bit_out),
	.duplex_select_bit_out(duplex_select_bit_out),
	.advert_10fd_out(advert_10fd_out), .advert_10hd_out(advert_10hd_out),
	.special_mode_out(special_mode_out)
);
`default_nettype wire

// ===== tb/ssl_loader_model.sv
// eeprom loader stand-in facing the strap latch
`timescale 1ns/10ps
`default_nettype none

module ssl_loader_model
(
	input wire logic sys_clk_in,
	input wire logic start_in,
	input wire logic present_in,
	input wire ssl_pkg::ssl_strap_t image_in,
	output logic wr_out,
	output var ssl_pkg::ssl_strap_t data_out,
	output logic done_out
);
	// after a start: wait, hand over one strap set, then report done
	initial
	begin
		wr_out = 1'h0;
		done_out = 1'h0;
		data_out = '0;
		forever
		begin
			@(posedge sys_clk_in);
			#1;
			if (start_in === 1'h1 && present_in === 1'h1)
			begin
				repeat (5) @(posedge sys_clk_in);
				wr_out <= 1'h1;
				data_out <= image_in;
				@(posedge sys_clk_in);
				wr_out <= 1'h0;
				done_out <= 1'h1;
				data_out <= ~image_in; // stale word is not held
				@(posedge sys_clk_in);
				done_out <= 1'h0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the soft strap latch
`timescale 1ns/10ps
`default_nettype none
`include "ssl_map.svh"

module tb_top;
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic ext_n = 1'h1;
	logic [5:0] pins = 6'h35;
	logic present = 1'h0;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	ssl_pkg::ssl_strap_t image = 15'h2D28;
	ssl_pkg::ssl_strap_t ld_data;
	logic ld_wr, ld_done, start, valid, xa, xc, ne, sp, du, fd, hd;
	logic [31:0] rdata, d;
	logic [7:0] sel;
	logic [1:0] fun;
	logic [2:0] mode;
	int n_mismatch = 0;
	int check_count = 0;

	// 20 MHz clock
	initial forever #25 sys_clk = ~sys_clk;

	ssl_strap_latch #(.ADDR_W(8)) uut (
		.sys_clk_in(sys_clk), .rst_n_in(rst_n),
		.external_reset_pin_n_in(ext_n), .led_select_strap_in(pins[5]),
		.led_function_strap_in(pins[4:3]), .auto_crossover_strap_in(pins[2]),
		.negotiation_strap_in(pins[1]), .speed_strap_in(pins[0]),
		.eeprom_present_in(present), .loader_wr_in(ld_wr),
		.loader_data_in(ld_data), .loader_done_in(ld_done),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .loader_start_out(start),
		.straps_valid_out(valid), .led_select_bits_out(sel),
		.led_function_bits_out(fun), .crossover_auto_out(xa),
		.crossover_cross_out(xc), .negotiation_enable_bit_out(ne),
		.speed_select_low_bit_out(sp), .duplex_select_bit_out(du),
		.advert_10fd_out(fd), .advert_10hd_out(hd), .special_mode_out(mode));

	ssl_loader_model partner (.sys_clk_in(sys_clk), .start_in(start),
		.present_in(present), .image_in(image), .wr_out(ld_wr),
		.data_out(ld_data), .done_out(ld_done));

	task check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task results;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// bounded wait: 0 valid, 1 loader start, 2 loader done
	task wait_hi(input int s);
		for (int i = 0; i < 200; i++)
		begin
			#1;
			if ((s == 0 && valid === 1'h1) || (s == 1 && start === 1'h1)
				|| (s == 2 && ld_done === 1'h1))
				return;
			@(posedge sys_clk);
		end
		n_mismatch++;
		results();
	endtask

	task reg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'h1;
		@(posedge sys_clk);
		wr <= 1'h0;
	endtask

	task reg_read(input logic [7:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge sys_clk);
		rd <= 1'h0;
		#1;
		d = rdata;
	endtask

	task settle;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	task s_capture;
		wait_hi(0);
		settle();
		check({fun, sel}, 10'h2FF);
		check({ne, sp, du, fd, hd, mode}, 8'h63);
		check({xa, xc}, 2'h2);
		reg_read(`SSL_OFF_CAPTURED);
		check(d, 32'h7FD3);
	endtask

	// pins move, then both soft resets must restore the old capture
	task s_revert;
		@(posedge sys_clk);
		pins <= 6'h0A;
		for (int k = 0; k < 2; k++)
		begin
			reg_write(`SSL_OFF_LED_CONFIG, 32'h155);
			settle();
			check({fun, sel}, 10'h155);
			reg_write(k ? `SSL_OFF_EEP_COMMAND : `SSL_OFF_RST_CONTROL, 32'h1);
			wait_hi(1);
			check(start, 1'h1);
			settle();
			check({fun, sel}, 10'h2FF);
			check({ne, sp, du, fd, hd, mode}, 8'h63);
		end
	endtask

	task s_loader;
		@(posedge sys_clk);
		present <= 1'h1;
		reg_write(`SSL_OFF_RST_CONTROL, 32'h1);
		wait_hi(2);
		settle();
		check({fun, sel}, 10'h15A);
		check({ne, sp, du, fd, hd, mode}, 8'h08);
		check({xa, xc}, 2'h1);
		reg_read(`SSL_OFF_CAPTURED);
		check(d, 32'h7FD3);
	endtask

	task s_override;
		reg_write(`SSL_OFF_SPEC_CTRL, 32'hC000);
		settle();
		check({xa, xc}, 2'h2);
		reg_write(`SSL_OFF_SPEC_CTRL, 32'h2000);
		settle();
		check({xa, xc}, 2'h1);
	endtask

	task s_unmapped;
		reg_write(8'h40, 32'hFFFF);
		reg_read(8'h40);
		check(d, 32'h0);
		reg_read(`SSL_OFF_LED_CONFIG);
		check(d, 32'h15A);
		// software writes to the other defaulted registers, then read back
		reg_write(`SSL_OFF_BASIC_CTRL, 32'h3100);
		reg_write(`SSL_OFF_NEG_ADVERT, 32'h40);
		reg_write(`SSL_OFF_SPEC_MODES, 32'hA0);
		reg_read(`SSL_OFF_BASIC_CTRL);
		check(d, 32'h3100);
		check({ne, sp, du, fd, hd, mode}, 8'hF5);
		reg_read(`SSL_OFF_NEG_ADVERT);
		check(d, 32'h40);
		reg_read(`SSL_OFF_SPEC_MODES);
		check(d, 32'hA0);
		// loader finished with eeprom present: busy low, present high
		reg_read(`SSL_OFF_EEP_COMMAND);
		check(d, 32'h4);
		reg_read(`SSL_OFF_RST_CONTROL);
		check(d, 32'h0);
	endtask

	task s_pin_reset;
		@(posedge sys_clk);
		present <= 1'h0;
		ext_n <= 1'h0;
		settle();
		check(valid, 1'h0);
		@(posedge sys_clk);
		ext_n <= 1'h1;
		wait_hi(0);
		settle();
		check({fun, sel}, 10'h100);
		check({ne, sp, du, fd, hd, mode}, 8'hFF);
		check({xa, xc}, 2'h0);
		reg_read(`SSL_OFF_CAPTURED);
		check(d, 32'h25);
	endtask

	// main sequence
	initial
	begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'h1;
		s_capture();
		s_revert();
		s_loader();
		s_override();
		s_unmapped();
		s_pin_reset();
		results();
	end

	// watchdog
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		results();
	end
endmodule
`default_nettype wire
